// [hw/svs_consts.svh]
// svs_consts.svh: offsets, field positions and reset values of the status block
// assumes: included by bare name from package and modules
`ifndef SVS_CONSTS_SVH
`define SVS_CONSTS_SVH

// register indices (word offsets); byte address is four times the index
`define SVS_IDX_FLAGS      4
`define SVS_IDX_STOPNODE   5
`define SVS_IDX_MISS_OUT   6
`define SVS_IDX_MISS_IN    7
`define SVS_IDX_UNREG_OUT  8
`define SVS_IDX_UNREG_IN   9
`define SVS_IDX_CTRL       10
`define SVS_IDX_IRQ_STAT   11
`define SVS_IDX_IRQ_MASK   12

`define SVS_ADDR_FLAGS     12'h010
`define SVS_ADDR_STOPNODE  12'h014
`define SVS_ADDR_MISS_OUT  12'h018
`define SVS_ADDR_MISS_IN   12'h01c
`define SVS_ADDR_UNREG_OUT 12'h020
`define SVS_ADDR_UNREG_IN  12'h024
`define SVS_ADDR_CTRL      12'h028
`define SVS_ADDR_IRQ_STAT  12'h02c
`define SVS_ADDR_IRQ_MASK  12'h030

// field positions in the flags word
`define SVS_BIT_REGDONE    0
`define SVS_BIT_MISSING    8
`define SVS_BIT_UNREG      9
`define SVS_BIT_STOPPED    10
`define SVS_BIT_ERROR      15
// field positions in the stopped-node word
`define SVS_BIT_STYPE      15
// control word fields
`define SVS_BIT_REGEN      0
`define SVS_BIT_STOPEN     1

`define SVS_RESET_WORD     16'h0000
`define SVS_NODES          16
`endif

// [hw/svs_pkg.sv]
// svs_pkg: types shared by the status block modules
// assumes: svs_consts.svh on the include path
`include "svs_consts.svh"
package svs_pkg;
    typedef logic [`SVS_NODES-1:0] svs_map_t;
    typedef enum logic [1:0] {
        SVS_IDLE    = 2'b00,
        SVS_MONITOR = 2'b01,
        SVS_RUN     = 2'b10
    } svs_phase_t;
endpackage

// [hw/svs_evt_if.sv]
// svs_evt_if: event bundle from verification core to register slave
// assumes: single clock domain
`timescale 1ns/1ps
`default_nettype none
interface svs_evt_if;
    import svs_pkg::*;
    logic [3:0] evt;      // regdone, missing, unreg, stopped rising events
    modport core (output evt);
    modport regs (input evt);
endinterface
`default_nettype wire

// [hw/svs_verify_core.sv]
// svs_verify_core: registration verification and communications-stop capture
// assumes: participation inputs are synchronous levels, one per node
`timescale 1ns/1ps
`default_nettype none
`include "svs_consts.svh"
module svs_verify_core
    import svs_pkg::*;
(
    input  wire logic       core_clk,     // system clock
    input  wire logic       resetn,       // async reset, low active
    input  wire logic       regEnable,    // registration check enabled
    input  wire logic       stopEnable,   // communications-stop mode
    input  wire svs_map_t   regOut,       // registered output slaves
    input  wire svs_map_t   regIn,        // registered input slaves
    input  wire svs_map_t   joinedOut,    // output slaves now in network
    input  wire svs_map_t   joinedIn,     // input slaves now in network
    input  wire logic       monitorDone,  // monitoring time elapsed, pulse
    input  wire logic       commErr,      // comm error halted exchange, pulse
    input  wire logic [3:0] errNode,      // node of faulting slave
    input  wire logic       errIsInput,   // faulting slave is an input slave
    output logic [15:0]     flagsWord,    // status flags word
    output logic [15:0]     stopWord,     // stopped node record
    output svs_map_t        missOut,      // missing output slaves
    output svs_map_t        missIn,       // missing input slaves
    output svs_map_t        unregOut,     // unregistered output slaves
    output svs_map_t        unregIn,      // unregistered input slaves
    svs_evt_if.core         evtBus        // events to the register slave
);
    typedef struct packed {
        svs_phase_t phase;
        logic       regDone;
        logic       stopped;
        logic [3:0] node;
        logic       sType;
        svs_map_t   missOut;
        svs_map_t   missIn;
        svs_map_t   unregOut;
        svs_map_t   unregIn;
        logic [3:0] evt;
    } svs_core_t;
    svs_core_t state_reg, state_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        state_next.evt = 4'h0;
        if (state_reg.phase == SVS_IDLE) begin
            state_next.phase = SVS_MONITOR;
        end
        if (regEnable && state_reg.phase != SVS_IDLE) begin
            state_next.unregOut = state_reg.unregOut | (joinedOut & ~regOut);
            state_next.unregIn  = state_reg.unregIn | (joinedIn & ~regIn);
            if (state_reg.phase == SVS_MONITOR && monitorDone) begin
                state_next.phase = SVS_RUN;
                if ((regOut | regIn) != '0 &&
                    (regOut & ~joinedOut) == '0 && (regIn & ~joinedIn) == '0) begin
                    state_next.regDone = 1'b1;
                end
                state_next.missOut = regOut & ~joinedOut;
                state_next.missIn  = regIn & ~joinedIn;
            end else if (state_reg.phase == SVS_RUN) begin
                // clears itself as the slave joins
                state_next.missOut = state_reg.missOut & ~joinedOut;
                state_next.missIn  = state_reg.missIn & ~joinedIn;
            end
        end
        // first stop captures node and type
        if (stopEnable && commErr && !state_reg.stopped) begin
            state_next.stopped = 1'b1;
            state_next.node    = errNode;
            state_next.sType   = errIsInput;
        end
        // rising edges feed the sticky interrupt status
        state_next.evt[0] = state_next.regDone & ~state_reg.regDone;
        state_next.evt[1] = ((state_next.missOut | state_next.missIn) != '0) &&
                            ((state_reg.missOut | state_reg.missIn) == '0);
        state_next.evt[2] = ((state_next.unregOut | state_next.unregIn) != '0) &&
                            ((state_reg.unregOut | state_reg.unregIn) == '0);
        state_next.evt[3] = state_next.stopped & ~state_reg.stopped;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // status words
    // ------------------------------------------------------------
    always_comb begin
        flagsWord = `SVS_RESET_WORD;
        flagsWord[`SVS_BIT_REGDONE] = state_reg.regDone;
        flagsWord[`SVS_BIT_MISSING] = (state_reg.missOut | state_reg.missIn) != '0;
        flagsWord[`SVS_BIT_UNREG]   = (state_reg.unregOut | state_reg.unregIn) != '0;
        flagsWord[`SVS_BIT_STOPPED] = state_reg.stopped;
        // summary is or of the three
        flagsWord[`SVS_BIT_ERROR]   = flagsWord[`SVS_BIT_MISSING] |
                                      flagsWord[`SVS_BIT_UNREG] | state_reg.stopped;
        stopWord = {state_reg.sType, 7'h00, 4'h0, state_reg.node};
    end
    assign missOut    = state_reg.missOut;
    assign missIn     = state_reg.missIn;
    assign unregOut   = state_reg.unregOut;
    assign unregIn    = state_reg.unregIn;
    assign evtBus.evt = state_reg.evt;
endmodule
`default_nettype wire

// [hw/svs_status_top.sv]
// svs_status_top: slave verification status bank with APB slave and interrupt
// assumes: one clock; participation and error inputs synchronous to core_clk
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "svs_consts.svh"
// How it works
// - flag registration complete when all registered slaves joined in time.
// - never flag registration complete with an empty registration table.
// - flag missing slaves after monitoring; clear as they join.
// - flag unregistered slave joining; sticky until restart.
// - in stop mode, flag communications stopped on error; sticky.
// - summary error flag is or of missing, unregistered, stopped.
// - store faulting node number in low byte of stop record.
// - stored node number held until restart.
// - store faulting slave type in bit 15: 1 input, 0 output.
// - slave type bit held until restart.
// - missing nodes marked in output and input bitmaps, words six, seven.
module svs_status_top
    import svs_pkg::*;
(
    input  wire logic        core_clk,    // 125 MHz clock
    input  wire logic        resetn,      // async reset, unit restart
    input  wire logic [11:0] paddr,       // apb address
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb enable
    input  wire logic        pwrite,      // apb direction
    input  wire logic [31:0] pwdata,      // apb write data
    output logic      [31:0] prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error
    input  wire svs_map_t    regOut,      // registered output slaves
    input  wire svs_map_t    regIn,       // registered input slaves
    input  wire svs_map_t    joinedOut,   // output slaves in network
    input  wire svs_map_t    joinedIn,    // input slaves in network
    input  wire logic        monitorDone, // monitoring time elapsed pulse
    input  wire logic        commErr,     // comm error halted exchange pulse
    input  wire logic [3:0]  errNode,     // node of faulting slave
    input  wire logic        errIsInput,  // faulting slave type
    output logic             irq          // level interrupt
);
    svs_evt_if evtBus();
    logic [15:0] flagsWord;
    logic [15:0] stopWord;
    svs_map_t    missOut, missIn, unregOut, unregIn;

    typedef struct packed {
        logic [1:0]  ctrl;
        logic [3:0]  irqStat;
        logic [3:0]  irqMask;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        irq;
    } svs_top_t;
    svs_top_t state_reg, state_next;

    svs_verify_core core_u (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .regEnable   (state_reg.ctrl[`SVS_BIT_REGEN]),
        .stopEnable  (state_reg.ctrl[`SVS_BIT_STOPEN]),
        .regOut      (regOut),
        .regIn       (regIn),
        .joinedOut   (joinedOut),
        .joinedIn    (joinedIn),
        .monitorDone (monitorDone),
        .commErr     (commErr),
        .errNode     (errNode),
        .errIsInput  (errIsInput),
        .flagsWord   (flagsWord),
        .stopWord    (stopWord),
        .missOut     (missOut),
        .missIn      (missIn),
        .unregOut    (unregOut),
        .unregIn     (unregIn),
        .evtBus      (evtBus.core)
    );

    // ------------------------------------------------------------
    // apb slave: one wait state, ready in the access cycle's next edge
    // ------------------------------------------------------------
    always_comb begin
        logic access;
        access               = psel && penable && !state_reg.ready;
        state_next           = state_reg;
        state_next.ready     = access;
        state_next.err       = 1'b0;
        state_next.rdata     = 32'h0000_0000;
        // sticky status: set wins over write-one clear
        state_next.irqStat   = state_reg.irqStat;
        if (access && pwrite && paddr == `SVS_ADDR_IRQ_STAT) begin
            state_next.irqStat = state_reg.irqStat & ~pwdata[3:0];
        end
        state_next.irqStat   = state_next.irqStat | evtBus.evt;
        if (access) begin
            // status words are read only; writes to them are refused
            unique case (paddr)
                `SVS_ADDR_FLAGS:     state_next.rdata = {16'h0000, flagsWord};
                `SVS_ADDR_STOPNODE:  state_next.rdata = {16'h0000, stopWord};
                `SVS_ADDR_MISS_OUT:  state_next.rdata = {16'h0000, missOut};
                `SVS_ADDR_MISS_IN:   state_next.rdata = {16'h0000, missIn};
                `SVS_ADDR_UNREG_OUT: state_next.rdata = {16'h0000, unregOut};
                `SVS_ADDR_UNREG_IN:  state_next.rdata = {16'h0000, unregIn};
                `SVS_ADDR_CTRL: begin
                    state_next.rdata = {30'h0, state_reg.ctrl};
                    if (pwrite) begin
                        state_next.ctrl = pwdata[1:0];
                    end
                end
                `SVS_ADDR_IRQ_STAT:  state_next.rdata = {28'h000_0000, state_reg.irqStat};
                `SVS_ADDR_IRQ_MASK: begin
                    state_next.rdata = {28'h000_0000, state_reg.irqMask};
                    if (pwrite) begin
                        state_next.irqMask = pwdata[3:0];
                    end
                end
                default:             state_next.err = 1'b1;
            endcase
            if (pwrite && paddr inside {`SVS_ADDR_FLAGS, `SVS_ADDR_STOPNODE,
                    `SVS_ADDR_MISS_OUT, `SVS_ADDR_MISS_IN, `SVS_ADDR_UNREG_OUT,
                    `SVS_ADDR_UNREG_IN}) begin
                state_next.err = 1'b1;
            end
            if (pwrite) begin
                state_next.rdata = 32'h0000_0000;
            end
        end
        // interrupt is a level from unmasked sticky bits
        state_next.irq = (state_next.irqStat & state_next.irqMask) != 4'h0;
    end

    // control and status clear on reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata  = state_reg.rdata;
    assign pready  = state_reg.ready;
    assign pslverr = state_reg.err;
    assign irq     = state_reg.irq;
endmodule
`default_nettype wire

// [dv/svs_status_checker.sv]
// svs_status_checker: apb and status word properties of svs_status_top
// assumes: bound into svs_status_top, one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
`include "svs_consts.svh"
module svs_status_checker
    import svs_pkg::*;
(
    input wire logic        core_clk, // clock
    input wire logic        resetn,   // async reset
    input wire logic [11:0] paddr,    // apb address
    input wire logic        psel,     // apb select
    input wire logic        penable,  // apb enable
    input wire logic        pwrite,   // apb direction
    input wire logic [31:0] prdata,   // apb read data
    input wire logic        pready,   // apb ready
    input wire logic        pslverr,  // apb error
    input wire svs_map_t    regOut,   // output table
    input wire svs_map_t    regIn     // input table
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ----------
    // helpers
    // ----------
    logic [2:0] seen_reg; // sticky flags seen set since restart
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_read(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    // only a unit restart may drop a sticky flag, so reset clears memory
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seen_reg <= 3'h0;
        end else if (pready && !pwrite && paddr == `SVS_ADDR_FLAGS) begin
            seen_reg <= seen_reg | {prdata[10:9], prdata[0]};
        end
    end
    // ----------
    // properties
    // ----------
    a_ready_after: assert property (s_access |=> pready)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read data set");
    a_ro_refuse: assert property (pready && pwrite && paddr >= 12'h010 && paddr <= 12'h024
        |-> pslverr) else $error("read-only write accepted");
    a_error_sum: assert property (s_read(`SVS_ADDR_FLAGS) |->
        prdata[15] == (|prdata[10:8])) else $error("error flag not or of causes");
    a_empty_table: assert property (s_read(`SVS_ADDR_FLAGS) && (regOut | regIn) == 16'h0000
        |-> !prdata[0]) else $error("complete with empty table");
    a_node_range: assert property (s_read(`SVS_ADDR_STOPNODE) |->
        prdata[14:4] == 11'h000) else $error("stop record out of range");
    a_flags_sticky: assert property (s_read(`SVS_ADDR_FLAGS) |->
        ({prdata[10:9], prdata[0]} & seen_reg) == seen_reg) else $error("sticky flag lost");
endmodule
bind svs_status_top svs_status_checker u_chk (.core_clk(core_clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regOut(regOut), .regIn(regIn));
`default_nettype wire

// [dv/svs_slave_net.sv]
// svs_slave_net: behavioural field network of remote slaves
// assumes: bench calls its tasks just after a rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module svs_slave_net
    import svs_pkg::*;
(
    input  wire logic  core_clk,    // clock
    output svs_map_t   joinedOut,   // output slaves in network
    output svs_map_t   joinedIn,    // input slaves in network
    output logic       monitorDone, // monitoring time over
    output logic       commErr,     // exchange halted
    output logic [3:0] errNode,     // faulting node
    output logic       errIsInput   // faulting slave type
);
    initial begin
        {joinedOut, joinedIn, monitorDone, commErr, errNode, errIsInput} = '0;
    end
    // membership changes land at the next edge
    task automatic set_joined(input svs_map_t o, input svs_map_t i);
        @(posedge core_clk);
        joinedOut <= o;
        joinedIn  <= i;
    endtask
    // monitoring window closes: one-cycle pulse
    task automatic end_monitor();
        @(posedge core_clk);
        monitorDone <= 1'b1;
        @(posedge core_clk);
        monitorDone <= 1'b0;
    endtask
    // node and type valid only with the pulse; inverted after, so stale reads show
    task automatic halt(input logic [3:0] n, input logic t);
        @(posedge core_clk);
        commErr    <= 1'b1;
        errNode    <= n;
        errIsInput <= t;
        @(posedge core_clk);
        commErr    <= 1'b0;
        errNode    <= ~n;
        errIsInput <= ~t;
    endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// tb: self-checking bench for svs_status_top
// assumes: svs_slave_net plays the network, bench is the apb master
`timescale 1ns/1ps
`default_nettype none
`include "svs_consts.svh"
module tb
    import svs_pkg::*;
;
    logic        core_clk, resetn, psel, penable, pwrite, e;
    logic        pready, pslverr, irq, monitorDone, commErr, errIsInput;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, rnd;
    logic [3:0]  errNode, node;
    svs_map_t    regOut, regIn, joinedOut, joinedIn, ro, jo, un, ri, ji;
    int          seed, mismatches, compares, cyc;
    svs_status_top u_dut (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .regOut(regOut), .regIn(regIn), .joinedOut(joinedOut),
        .joinedIn(joinedIn), .monitorDone(monitorDone), .commErr(commErr),
        .errNode(errNode), .errIsInput(errIsInput), .irq(irq));
    svs_slave_net u_net (.core_clk(core_clk), .joinedOut(joinedOut), .joinedIn(joinedIn),
        .monitorDone(monitorDone), .commErr(commErr), .errNode(errNode),
        .errIsInput(errIsInput));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // hang guard: the scenarios need well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [31:0] f_flags(logic d, logic m, logic u, logic s);
        return {16'h0000, m | u | s, 4'h0, s, u, m, 7'h00, d};
    endfunction
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16) chk("apb answer", 32'h1, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, r);
    endtask
    task automatic rst();
        resetn <= 1'b0;
        regOut <= 16'h0000;
        regIn  <= 16'h0000;
        u_net.set_joined(16'h0000, 16'h0000);
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
    endtask
    // tables first, then both functions enabled, network joins, window closes
    // host never writes the status words while functions run
    task automatic verify(input svs_map_t o, input svs_map_t i, input svs_map_t j,
            input svs_map_t ji);
        regOut <= o;
        regIn  <= i;
        apb(1'b1, `SVS_ADDR_CTRL, 32'h3);
        u_net.set_joined(j, ji);
        u_net.end_monitor();
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
        seed = 32'h4638;
        rst();
        rd(`SVS_ADDR_FLAGS, 32'h0, "flags after reset");
        rd(`SVS_ADDR_STOPNODE, 32'h0, "stop word after reset");
        rd(12'h0fc, 32'h0, "unmapped read");
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, `SVS_ADDR_FLAGS, 32'hffff);
        chk("read-only error", 32'h1, {31'h0, e});
        // a halt with stop mode off must leave no trace
        u_net.halt(4'h5, 1'b1);
        rd(`SVS_ADDR_FLAGS, 32'h0, "stop mode off");
        rd(`SVS_ADDR_STOPNODE, 32'h0, "no record when off");
        $display("test reset and refusal done");
        rnd = $random(seed);
        verify(16'h0000, 16'h0000, rnd[15:0], 16'h0000);
        rd(`SVS_ADDR_FLAGS, f_flags(1'b0, 1'b0, |rnd[15:0], 1'b0), "empty table");
        $display("test empty table done");
        // missing node 0, unregistered node 15 and others, then membership fixed
        rst();
        rnd = $random(seed);
        ro = rnd[15:0] & 16'h7fff | 16'h0001;
        jo = (ro & rnd[31:16] & 16'hfffe) | (~ro & rnd[31:16]) | 16'h8000;
        // input node 1 missing, input node 15 unregistered
        ri = rnd[31:16] & 16'h7fff | 16'h0002;
        ji = ri & 16'hfffd | 16'h8000;
        verify(ro, ri, jo, ji);
        rd(`SVS_ADDR_FLAGS, f_flags(1'b0, 1'b1, 1'b1, 1'b0), "flags missing");
        rd(`SVS_ADDR_MISS_OUT, {16'h0, ro & ~jo}, "missing outputs");
        rd(`SVS_ADDR_MISS_IN, 32'h0000_0002, "missing inputs");
        rd(`SVS_ADDR_UNREG_OUT, {16'h0, jo & ~ro}, "unregistered outputs");
        rd(`SVS_ADDR_UNREG_IN, 32'h0000_8000, "unregistered inputs");
        u_net.set_joined(ro, ri);
        rd(`SVS_ADDR_MISS_OUT, 32'h0, "missing after join");
        rd(`SVS_ADDR_MISS_IN, 32'h0, "missing inputs after join");
        rd(`SVS_ADDR_FLAGS, f_flags(1'b0, 1'b0, 1'b1, 1'b0), "unreg sticky");
        rd(`SVS_ADDR_UNREG_OUT, {16'h0, jo & ~ro}, "unreg map sticky");
        $display("test verification errors done");
        // completion, two stops of which only the first counts, masked irq
        for (int k = 0; k < 4; k++) begin
            rst();
            rnd = $random(seed);
            ro = rnd[15:0] | 16'h0001;
            un = rnd[31:16] & ~ro;
            node = rnd[7:4];
            apb(1'b1, `SVS_ADDR_IRQ_MASK, 32'h8);
            verify(ro, rnd[31:16], ro | un, rnd[31:16]);
            chk("irq masked", 32'h0, {31'h0, irq});
            u_net.halt(node, k[0]);
            u_net.halt(~node, ~k[0]);
            repeat (3) @(posedge core_clk);
            chk("irq stopped", 32'h1, {31'h0, irq});
            rd(`SVS_ADDR_FLAGS, f_flags(1'b1, 1'b0, |un, 1'b1), "flags done");
            rd(`SVS_ADDR_STOPNODE, {16'h0, k[0], 11'h0, node}, "stop rec");
            rd(`SVS_ADDR_IRQ_STAT, {28'h0, 1'b1, |un, 2'b01}, "irq status");
            apb(1'b1, `SVS_ADDR_IRQ_STAT, 32'h8);
            repeat (2) @(posedge core_clk);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        $display("test completion and stop done");
        give_verdict();
    end
endmodule
`default_nettype wire
